// ==== core/mirror_seq_params.svh ====
// Timing and sizing constants for the mirror array supply sequencer.
// Operation
// - Core logic supply must be up and settled before any mirror supply.
// - Bias supply enabled only after offset supply is good and delay elapsed.
// - Offset-to-bias delay is at least 1 ms, nominally 2 ms.
// - Reset supply may switch in either order relative to the bias supply.
// - All single-ended CMOS inputs stay low until the core supply settles.
// - Core supply stays on until bias, reset and offset have discharged.
// - Offset power-good must stay high after offset enable falls, for a hold.
// - Offset power-good hold after offset enable falls is at least 100 ns.
// - Supplies enabled only after mirror output enable (active low) is high.
// - Global mirror bias command issued after supplies are up, before running.
// - Orderly shutdown parks mirrors, then asserts power-down, then drops rails.
// - In emergency park, offset enable may fall after offset power-good.
// - In emergency park, park-done flag goes high before offset power-good drops.
`ifndef MIRROR_SEQ_PARAMS_SVH
`define MIRROR_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS        50
`define OFFSET_TO_BIAS_NS    2000000
`define POWER_GOOD_HOLD_NS   100
`define PARK_TIMEOUT_NS      1000000
`define TIMER_WIDTH          16

// Least times round up to whole clock cycles.
`define NS_TO_CYCLES(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== core/mirror_seq_pkg.sv ====
// Types shared by the mirror array supply sequencer.
package mirror_seq_pkg;

  typedef enum logic [3:0] {
    SEQ_OFF,
    SEQ_CORE_UP,
    SEQ_OFFSET_UP,
    SEQ_WAIT_DELAY,
    SEQ_RAILS_UP,
    SEQ_BIAS_CMD,
    SEQ_RUN,
    SEQ_PARK,
    SEQ_DISABLE_RAILS,
    SEQ_WAIT_DISCHARGE,
    SEQ_CORE_OFF,
    SEQ_EPARK,
    SEQ_EFLAG,
    SEQ_EDISABLE
  } seq_state_t;

  typedef struct packed {
    logic core;
    logic offset;
    logic bias;
    logic reset;
  } rails_t;

  typedef struct packed {
    logic core;
    logic offset;
    logic bias;
    logic reset;
  } rails_good_t;

endpackage : mirror_seq_pkg

// ==== core/delay_timer.sv ====
// Loadable down-counter that reports when a loaded delay has run out.
`timescale 1ns/10ps
module delay_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             done_q;
  logic             done_d;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (load) begin
      cnt_d  = count;
      done_d = 1'b0;
    end else if (cnt_q > 1) begin
      cnt_d = cnt_q - 1'b1;
    end else begin
      cnt_d  = '0;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule : delay_timer

// ==== core/mirror_array_supply_sequencer.sv ====
// Power-up, power-down and emergency park sequencer for the mirror rails.
`timescale 1ns/10ps
`include "mirror_seq_params.svh"
module mirror_array_supply_sequencer #(
  parameter int TW                  = `TIMER_WIDTH,
  parameter int OFFSET_TO_BIAS_CYC  = `NS_TO_CYCLES(`OFFSET_TO_BIAS_NS),
  parameter int PARK_TIMEOUT_CYC    = `NS_TO_CYCLES(`PARK_TIMEOUT_NS)
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       ce,
  input  wire logic                       powerOnReq,
  input  wire logic                       powerOffReq,
  input  wire logic                       powerLoss,
  input  wire mirror_seq_pkg::rails_good_t railsGood,
  input  wire logic                       railsDischarged,
  input  wire logic                       mirrorOutputEnableN,
  input  wire logic                       parkComplete,
  output mirror_seq_pkg::rails_t          railEn,
  output logic                            cmosDriveEn,
  output logic                            biasCmd,
  output logic                            parkReq,
  output logic                            powerDownN,
  output logic                            parkDoneFlag,
  output logic                            running,
  output logic                            holdFault,
  output mirror_seq_pkg::seq_state_t      seqState
);
  import mirror_seq_pkg::*;

  // ---------------------------------------------------------------------
  // Timing constants
  // ---------------------------------------------------------------------
  localparam logic [TW-1:0] OffsetToBias = TW'(OFFSET_TO_BIAS_CYC);
  localparam logic [TW-1:0] PgHold       =
    TW'(`NS_TO_CYCLES(`POWER_GOOD_HOLD_NS));
  localparam logic [TW-1:0] ParkTimeout  = TW'(PARK_TIMEOUT_CYC);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  seq_state_t state_q;
  seq_state_t state_d;
  rails_t     rails_q;
  rails_t     rails_d;
  logic       cmos_q;
  logic       cmos_d;
  logic       biasCmd_q;
  logic       biasCmd_d;
  logic       parkReq_q;
  logic       parkReq_d;
  logic       pdn_q;
  logic       pdn_d;
  logic       parkFlag_q;
  logic       parkFlag_d;
  logic       holdFault_q;
  logic       holdFault_d;
  logic       holdWatch_q;
  logic       holdWatch_d;
  logic       timerLoad;
  logic [TW-1:0] timerCount;
  logic       timerDone;

  delay_timer #(
    .WIDTH (TW)
  ) u_timer (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .load  (timerLoad),
    .count (timerCount),
    .done  (timerDone)
  );

  // True in every state where a power loss must divert the sequence. Once
  // the mirror rails are disabled the discharge wait already guards them,
  // so a loss there must not drop the core rail before they discharge.
  function automatic logic powered(input seq_state_t s);
    powered = (s != SEQ_OFF) && (s != SEQ_EPARK) && (s != SEQ_EFLAG) &&
              (s != SEQ_EDISABLE) && (s != SEQ_CORE_OFF) &&
              (s != SEQ_WAIT_DISCHARGE);
  endfunction : powered

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    rails_d     = rails_q;
    cmos_d      = cmos_q;
    biasCmd_d   = 1'b0;
    parkReq_d   = parkReq_q;
    pdn_d       = pdn_q;
    parkFlag_d  = parkFlag_q;
    holdFault_d = holdFault_q;
    holdWatch_d = holdWatch_q;
    timerLoad   = 1'b0;
    timerCount  = '0;

    // The hold watch looks for power-good falling too soon after the
    // offset enable dropped; it only runs in a normal power-down.
    if (holdWatch_q) begin
      if (timerDone) begin
        holdWatch_d = 1'b0;
      end else if (!railsGood.offset) begin
        holdFault_d = 1'b1;
        holdWatch_d = 1'b0;
      end
    end

    case (state_q)
      SEQ_OFF: begin
        rails_d    = '0;
        cmos_d     = 1'b0;
        parkReq_d  = 1'b0;
        pdn_d      = 1'b0;
        parkFlag_d = 1'b0;
        if (powerOnReq && mirrorOutputEnableN && !powerLoss) begin
          rails_d.core = 1'b1;
          holdFault_d  = 1'b0;
          state_d      = SEQ_CORE_UP;
        end
      end
      SEQ_CORE_UP: begin
        if (railsGood.core) begin
          cmos_d         = 1'b1;
          pdn_d          = 1'b1;
          rails_d.offset = 1'b1;
          state_d        = SEQ_OFFSET_UP;
        end
      end
      SEQ_OFFSET_UP: begin
        if (railsGood.offset) begin
          timerLoad  = 1'b1;
          timerCount = OffsetToBias;
          state_d    = SEQ_WAIT_DELAY;
        end
      end
      SEQ_WAIT_DELAY: begin
        if (timerDone && !timerLoad) begin
          // Bias and reset rise together; their order does not matter.
          rails_d.bias  = 1'b1;
          rails_d.reset = 1'b1;
          state_d       = SEQ_RAILS_UP;
        end
      end
      SEQ_RAILS_UP: begin
        if (railsGood.bias && railsGood.reset) begin
          biasCmd_d = 1'b1;
          state_d   = SEQ_BIAS_CMD;
        end
      end
      SEQ_BIAS_CMD: begin
        state_d = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (powerOffReq) begin
          parkReq_d  = 1'b1;
          timerLoad  = 1'b1;
          timerCount = ParkTimeout;
          state_d    = SEQ_PARK;
        end
      end
      SEQ_PARK: begin
        // A controller that never reports completion must not hold the
        // rails up forever, so the park is bounded by a timeout.
        if (parkComplete || (timerDone && !timerLoad)) begin
          parkReq_d = 1'b0;
          pdn_d     = 1'b0;
          state_d   = SEQ_DISABLE_RAILS;
        end
      end
      SEQ_DISABLE_RAILS: begin
        rails_d.bias   = 1'b0;
        rails_d.reset  = 1'b0;
        rails_d.offset = 1'b0;
        cmos_d         = 1'b0;
        timerLoad      = 1'b1;
        timerCount     = PgHold;
        holdWatch_d    = 1'b1;
        state_d        = SEQ_WAIT_DISCHARGE;
      end
      SEQ_WAIT_DISCHARGE: begin
        if (railsDischarged && !holdWatch_q) begin
          state_d = SEQ_CORE_OFF;
        end
      end
      SEQ_CORE_OFF: begin
        rails_d.core = 1'b0;
        if (!railsGood.core) begin
          state_d = SEQ_OFF;
        end
      end
      SEQ_EPARK: begin
        if (parkComplete || (timerDone && !timerLoad)) begin
          parkReq_d  = 1'b0;
          parkFlag_d = 1'b1;
          state_d    = SEQ_EFLAG;
        end
      end
      SEQ_EFLAG: begin
        // Offset enable drops only now, possibly after power-good fell.
        pdn_d          = 1'b0;
        cmos_d         = 1'b0;
        rails_d.bias   = 1'b0;
        rails_d.reset  = 1'b0;
        rails_d.offset = 1'b0;
        state_d        = SEQ_EDISABLE;
      end
      SEQ_EDISABLE: begin
        if (railsDischarged) begin
          parkFlag_d = 1'b0;
          state_d    = SEQ_CORE_OFF;
        end
      end
      default: begin
        state_d = SEQ_OFF;
      end
    endcase

    // Power loss overrides the normal ordering from any powered state.
    if (powerLoss && powered(state_q)) begin
      if (rails_q.offset || rails_q.bias || rails_q.reset) begin
        parkReq_d   = 1'b1;
        holdWatch_d = 1'b0;
        timerLoad   = 1'b1;
        timerCount  = ParkTimeout;
        rails_d     = rails_q;
        state_d     = SEQ_EPARK;
      end else begin
        cmos_d  = 1'b0;
        pdn_d   = 1'b0;
        rails_d = '0;
        state_d = SEQ_OFF;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q     <= SEQ_OFF;
      rails_q     <= '0;
      cmos_q      <= 1'b0;
      biasCmd_q   <= 1'b0;
      parkReq_q   <= 1'b0;
      pdn_q       <= 1'b0;
      parkFlag_q  <= 1'b0;
      holdFault_q <= 1'b0;
      holdWatch_q <= 1'b0;
    end else if (ce) begin
      state_q     <= state_d;
      rails_q     <= rails_d;
      cmos_q      <= cmos_d;
      biasCmd_q   <= biasCmd_d;
      parkReq_q   <= parkReq_d;
      pdn_q       <= pdn_d;
      parkFlag_q  <= parkFlag_d;
      holdFault_q <= holdFault_d;
      holdWatch_q <= holdWatch_d;
    end
  end

  assign railEn       = rails_q;
  assign cmosDriveEn  = cmos_q;
  assign biasCmd      = biasCmd_q;
  assign parkReq      = parkReq_q;
  assign powerDownN   = pdn_q;
  assign parkDoneFlag = parkFlag_q;
  assign running      = (state_q == SEQ_RUN);
  assign holdFault    = holdFault_q;
  assign seqState     = state_q;

endmodule : mirror_array_supply_sequencer

// ==== tb/mirror_seq_properties.sv ====
// Port checks for the mirror array supply sequencer.
`timescale 1ns/10ps
module mirror_seq_properties #(
  parameter int TW                 = 16,
  parameter int OFFSET_TO_BIAS_CYC = 20,
  parameter int PARK_TIMEOUT_CYC   = 30
) (
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic                        ce,
  input wire logic                        powerOnReq,
  input wire logic                        powerLoss,
  input wire mirror_seq_pkg::rails_good_t railsGood,
  input wire logic                        railsDischarged,
  input wire logic                        mirrorOutputEnableN,
  input wire mirror_seq_pkg::rails_t      railEn,
  input wire logic                        cmosDriveEn,
  input wire logic                        biasCmd,
  input wire logic                        parkReq,
  input wire logic                        powerDownN,
  input wire logic                        parkDoneFlag,
  input wire logic                        running,
  input wire logic                        holdFault,
  input wire mirror_seq_pkg::seq_state_t  seqState
);
  import mirror_seq_pkg::*;
  // ----------------------------------------------------------------
  // Offset settle counter
  // ----------------------------------------------------------------
  // Counts cycles the offset rail has been on and good, saturating.
  int goodRun_q;
  int goodRun_d;
  always_comb begin
    goodRun_d = goodRun_q;
    if (!(railEn.offset && railsGood.offset)) goodRun_d = 0;
    else if (goodRun_q < 65535) goodRun_d = goodRun_q + 1;
  end
  always_ff @(posedge clk) begin
    if (srst) goodRun_q <= 0;
    else goodRun_q <= goodRun_d;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence startReq;
    seqState == SEQ_OFF && powerOnReq && mirrorOutputEnableN && !powerLoss
      && ce;
  endsequence
  sequence lossInRun;
    running && powerLoss && ce;
  endsequence
  a_start_on_oe: assert property (startReq |=> railEn.core)
    else $error("core rail not raised on start");
  a_core_after_oe: assert property ($rose(railEn.core) |->
    $past(mirrorOutputEnableN)) else $error("core rail before oe high");
  a_offset_after_core: assert property ($rose(railEn.offset) |->
    $past(railsGood.core)) else $error("offset before core good");
  a_bias_delay: assert property ($rose(railEn.bias) |->
    goodRun_q >= OFFSET_TO_BIAS_CYC) else $error("bias too early");
  a_bias_reset_pair: assert property (railEn.bias == railEn.reset)
    else $error("bias and reset rails split");
  a_cmos_after_core: assert property (cmosDriveEn |->
    railEn.core && railsGood.core) else $error("cmos driven early");
  a_core_holds: assert property ($fell(railEn.core) |->
    $past(railsDischarged) && !$past(railEn.offset))
    else $error("core dropped before discharge");
  a_hold_fault: assert property ($fell(railEn.offset) &&
    !railsGood.offset |-> ##[0:3] holdFault) else $error("hold not flagged");
  a_cmd_then_run: assert property (biasCmd |=> running && !biasCmd)
    else $error("bias command not followed by run");
  a_run_after_cmd: assert property (
    $rose(running) |-> $past(biasCmd))
    else $error("run without bias command");
  a_park_before_down: assert property ($fell(railEn.bias) &&
    !parkDoneFlag |-> $past(!powerDownN) && !parkReq)
    else $error("rails dropped before park and power-down");
  a_flag_before_pg: assert property (
    $fell(railsGood.offset) && powerLoss |-> parkDoneFlag)
    else $error("park flag late");
  a_loss_parks: assert property (lossInRun |=> parkReq && !running)
    else $error("power loss did not park");
endmodule : mirror_seq_properties

bind mirror_array_supply_sequencer mirror_seq_properties #(
  .TW(TW), .OFFSET_TO_BIAS_CYC(OFFSET_TO_BIAS_CYC),
  .PARK_TIMEOUT_CYC(PARK_TIMEOUT_CYC)
) props_u (.clk, .srst, .ce, .powerOnReq, .powerLoss, .railsGood,
  .railsDischarged, .mirrorOutputEnableN, .railEn, .cmosDriveEn, .biasCmd,
  .parkReq, .powerDownN, .parkDoneFlag, .running, .holdFault, .seqState);

// ==== tb/supply_model.sv ====
// Behavioural rails, discharge and mirror park model beside the sequencer.
`timescale 1ns/10ps
module supply_model (
  input  wire logic                   clk,
  input  wire mirror_seq_pkg::rails_t railEn,
  input  wire logic                   parkReq,
  input  wire logic                   fastDrop,
  input  wire logic [7:0]             parkDelay,
  output mirror_seq_pkg::rails_good_t railsGood,
  output logic                        railsDischarged,
  output logic                        parkComplete
);
  import mirror_seq_pkg::*;
  rails_t     en1_q, en2_q, en3_q;
  logic [2:0] dis_q;
  logic [7:0] park_q;
  // Good follows the enable three cycles late both ways, so offset good
  // outlives its enable unless fastDrop models a collapsing rail.
  assign railsGood = {en3_q.core, en3_q.offset & (railEn.offset | ~fastDrop),
                      en3_q.bias, en3_q.reset};
  assign railsDischarged = (dis_q == 3'h4);
  // A parkDelay above the reachable count never completes the park.
  assign parkComplete = parkReq && (park_q == parkDelay);
  always_ff @(posedge clk) begin
    en1_q <= railEn;
    en2_q <= en1_q;
    en3_q <= en2_q;
    if ({en3_q.offset, en3_q.bias, en3_q.reset} != 3'h0) dis_q <= 3'h0;
    else if (dis_q != 3'h4) dis_q <= dis_q + 3'h1;
    if (!parkReq) park_q <= 8'h00;
    else if (park_q != 8'hFE) park_q <= park_q + 8'h01;
  end
endmodule : supply_model

// ==== tb/mirror_array_supply_sequencer_tb.sv ====
// Self-checking bench for the mirror array supply sequencer.
`timescale 1ns/10ps
module mirror_array_supply_sequencer_tb;
  import mirror_seq_pkg::*;
  logic        clk, srst, ce, powerOnReq, powerOffReq, powerLoss, fastDrop;
  logic        mirrorOutputEnableN, railsDischarged, parkComplete;
  logic        cmosDriveEn, biasCmd, parkReq, powerDownN;
  logic        parkDoneFlag, running, holdFault;
  logic [7:0]  parkDelay;
  rails_t      railEn;
  rails_good_t railsGood;
  seq_state_t  seqState;
  logic [5:0]  obs, obsPrev;
  logic [5:0]  expQ[$];
  int          err_total, checks_done, biasSeen;
  assign obs = {railEn, running, parkDoneFlag};

  mirror_array_supply_sequencer #(.OFFSET_TO_BIAS_CYC(20),
    .PARK_TIMEOUT_CYC(30)) dut_u (.clk, .srst, .ce, .powerOnReq,
    .powerOffReq, .powerLoss, .railsGood, .railsDischarged,
    .mirrorOutputEnableN, .parkComplete, .railEn, .cmosDriveEn, .biasCmd,
    .parkReq, .powerDownN, .parkDoneFlag, .running, .holdFault, .seqState);
  supply_model model_u (.clk, .railEn, .parkReq, .fastDrop, .parkDelay,
    .railsGood, .railsDischarged, .parkComplete);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic summarize;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Each change of the watched outputs must match the oldest note.
  always @(negedge clk) begin
    if (!srst && obs !== obsPrev) begin
      if (expQ.size() == 0) check({2'h0, obs}, 8'hFF);
      else check({2'h0, obs}, {2'h0, expQ.pop_front()});
    end
    if (!srst && biasCmd === 1'b1) biasSeen++;
    obsPrev <= obs;
  end

  // Random values on inputs that the present state must ignore.
  task automatic noise(input logic inRun);
    repeat (20) begin
      @(negedge clk);
      {ce, powerOnReq, fastDrop} = 3'($urandom);
      powerOffReq = !inRun && 1'($urandom);
      powerLoss = !inRun && 1'($urandom);
      mirrorOutputEnableN = inRun && 1'($urandom);
    end
    @(negedge clk);
    {ce, powerOnReq, powerOffReq, powerLoss, fastDrop} = 5'h10;
    mirrorOutputEnableN = 1'b1;
    @(negedge clk);
  endtask : noise

  task automatic waitObs(input logic [5:0] want);
    int n;
    n = 0;
    while (obs !== want && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (obs !== want) begin
      err_total++;
      $display("[ERR] t=%0t wait seen=%h want=%h", $time, obs, want);
      summarize();
    end
  endtask : waitObs

  task automatic powerUp;
    int b0;
    b0 = biasSeen;
    expQ.push_back(6'h20);
    expQ.push_back(6'h30);
    expQ.push_back(6'h3C);
    expQ.push_back(6'h3E);
    powerOnReq = 1'b1;
    waitObs(6'h20);
    powerOnReq = 1'b0;
    waitObs(6'h3E);
    check({7'h0, powerDownN}, 8'h01);
    check({7'h0, cmosDriveEn}, 8'h01);
    check(8'(biasSeen - b0), 8'h01);
  endtask : powerUp

  task automatic shutdown(input logic [7:0] delay, input logic fast);
    parkDelay = delay;
    fastDrop = fast;
    expQ.push_back(6'h3C);
    expQ.push_back(6'h20);
    expQ.push_back(6'h00);
    powerOffReq = 1'b1;
    waitObs(6'h3C);
    check({7'h0, parkReq}, 8'h01);
    powerOffReq = 1'b0;
    waitObs(6'h00);
    check({7'h0, holdFault}, {7'h0, fast});
    check({5'h0, powerDownN, cmosDriveEn, parkReq}, 8'h00);
    fastDrop = 1'b0;
  endtask : shutdown

  initial begin
    {srst, ce, mirrorOutputEnableN} = 3'h7;
    {powerOnReq, powerOffReq, powerLoss, fastDrop} = 4'h0;
    parkDelay = 8'h03;
    obsPrev = 6'h00;
    err_total = 0;
    checks_done = 0;
    biasSeen = 0;
    void'($urandom(97887));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    // Requests that must be ignored: off in OFF, on with oe low.
    noise(1'b0);
    check({4'h0, seqState}, {4'h0, SEQ_OFF});
    powerUp();
    noise(1'b1);
    check({4'h0, seqState}, {4'h0, SEQ_RUN});
    // A frozen clock enable must hold the run state despite a request.
    ce = 1'b0;
    powerOffReq = 1'b1;
    repeat (5) @(negedge clk);
    check({4'h0, seqState}, {4'h0, SEQ_RUN});
    ce = 1'b1;
    shutdown(8'($urandom_range(1, 10)), 1'b0);
    // Park never completes, so the timeout ends it; offset good collapses.
    powerUp();
    shutdown(8'hFF, 1'b1);
    powerUp();
    check({7'h0, holdFault}, 8'h00);
    parkDelay = 8'($urandom_range(1, 10));
    expQ.push_back(6'h3C);
    expQ.push_back(6'h3D);
    expQ.push_back(6'h21);
    expQ.push_back(6'h20);
    expQ.push_back(6'h00);
    powerLoss = 1'b1;
    waitObs(6'h00);
    powerLoss = 1'b0;
    // Loss while only the core rail is on.
    expQ.push_back(6'h20);
    expQ.push_back(6'h00);
    repeat (8) @(negedge clk);
    powerOnReq = 1'b1;
    waitObs(6'h20);
    {powerOnReq, powerLoss} = 2'h1;
    waitObs(6'h00);
    powerLoss = 1'b0;
    repeat (10) @(negedge clk);
    check(8'(expQ.size()), 8'h00);
    summarize();
  end
endmodule : mirror_array_supply_sequencer_tb
